// File: core/buffer_access_pkg.sv
// Purpose: Shared constants and types for the channel frame buffer block
// Assumes: 32-bit APB register side, 16-bit protocol engine words
// Notes:   Offsets are byte addresses on the APB bus
`default_nettype none
package buffer_access_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W    = 14;
  localparam int DATA_W    = 32;
  localparam int HALF_W    = 16;
  localparam int TX_PTR_W  = 12;
  localparam int RX_PTR_W  = 13;
  localparam int CNT_W     = 16;
  localparam int PRI_DEPTH = 8;   // 16 bytes of 16-bit words
  localparam int SEC_DEPTH = 2;   // 4 bytes of 16-bit words
  // ------------------------------------------------------------
  // Register map and windows
  // ------------------------------------------------------------
  localparam logic [13:0] OFS_CONTROL   = 14'h0000;
  localparam logic [13:0] OFS_STATUS    = 14'h0004;
  localparam logic [13:0] OFS_TX_COUNT  = 14'h0008;
  localparam logic [13:0] OFS_RX_COUNT  = 14'h000C;
  localparam logic [13:0] OFS_TX_DATA   = 14'h0010;
  localparam logic [13:0] OFS_RX_DATA   = 14'h0014;
  localparam logic [13:0] OFS_TX_RD_PTR = 14'h0018;
  localparam logic [13:0] OFS_TX_WR_PTR = 14'h001C;
  localparam logic [13:0] OFS_RX_RD_PTR = 14'h0020;
  localparam logic [13:0] OFS_RX_WR_PTR = 14'h0024;
  localparam logic [13:0] OFS_RX_START  = 14'h0028;
  localparam logic [1:0]  WIN_REGS      = 2'h0;
  localparam logic [1:0]  WIN_TX_MEM    = 2'h1;
  // ------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------
  localparam int CTL_MODE    = 0;
  localparam int CTL_START   = 1;
  localparam int CTL_SIZE_EN = 2;
  localparam int CTL_FW      = 3;
  localparam int ST_TX_DONE  = 0;
  localparam int ST_RX_DONE  = 1;
  localparam int ST_TX_BUSY  = 2;
  localparam int ST_RX_BUSY  = 3;
  localparam logic MODE_FIFO = 1'b0;
  localparam logic [11:0] TX_LWORD  = 12'h004;
  localparam logic [11:0] TX_HWORD  = 12'h002;
  localparam logic [12:0] RX_LWORD  = 13'h0004;
  localparam logic [12:0] RX_HWORD  = 13'h0002;
  localparam logic [15:0] CNT_HWORD = 16'h0002;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  typedef enum logic [1:0] {
    RX_RUN  = 2'b00,
    RX_ZERO = 2'b01,
    RX_HDR  = 2'b10
  } rx_state_type;
endpackage : buffer_access_pkg
`default_nettype wire

// File: core/channel_frame_buffer_access.sv
// Purpose: One channel of the peripheral buffer unit, APB side to engine side
// Assumes: Engine runs on pclk; data port and pointer rules per access mode
// Notes:   One APB wait state on every access
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module channel_frame_buffer_access (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [buffer_access_pkg::ADDR_W-1:0] paddr,
  input  wire logic [buffer_access_pkg::DATA_W-1:0] pwdata,
  output var  logic [buffer_access_pkg::DATA_W-1:0] prdata,
  output var  logic                                 pready,
  output var  logic                                 pslverr,
  output var  logic [buffer_access_pkg::HALF_W-1:0] eng_tx_data,
  output var  logic                                 eng_tx_valid,
  input  wire logic                                 eng_tx_ready,
  output var  logic                                 eng_fw_load,
  input  wire logic [buffer_access_pkg::HALF_W-1:0] eng_rx_data,
  input  wire logic                                 eng_rx_valid,
  output var  logic                                 eng_rx_ready,
  input  wire logic                                 eng_rx_end
);
  import buffer_access_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [DATA_W-1:0]   tx_mem [1024];
  logic [HALF_W-1:0]   rx_mem [4096];
  logic [HALF_W-1:0]   pri_mem [PRI_DEPTH];
  logic [HALF_W-1:0]   sec_mem [SEC_DEPTH];
  logic                mode_q, mode_d, size_en_q, size_en_d, fw_q, fw_d;
  logic                tx_done_q, tx_done_d, rx_done_q, rx_done_d;
  logic                tx_busy_q, tx_busy_d, rx_first_q, rx_first_d;
  logic                end_seen_q, end_seen_d;
  logic [CNT_W-1:0]    tx_count_q, tx_count_d, rx_count_q, rx_count_d;
  logic [CNT_W-1:0]    tx_sent_q, tx_sent_d, rx_hw_cnt_q, rx_hw_cnt_d;
  logic [TX_PTR_W-1:0] tx_rd_q, tx_rd_d, tx_wr_q, tx_wr_d;
  logic [RX_PTR_W-1:0] rx_rd_q, rx_rd_d, rx_wr_q, rx_wr_d, rx_start_q, rx_start_d;
  logic [RX_PTR_W-1:0] hdr_q, hdr_d;
  logic [2:0]          pri_wp_q, pri_wp_d, pri_rp_q, pri_rp_d;
  logic [3:0]          pri_cnt_q, pri_cnt_d;
  logic                sec_wp_q, sec_wp_d, sec_rp_q, sec_rp_d;
  logic [1:0]          sec_cnt_q, sec_cnt_d;
  logic [HALF_W-1:0]   tx_out_q, tx_out_d;
  logic                tx_out_vld_q, tx_out_vld_d, rx_rdy_q, rx_rdy_d;
  logic [DATA_W-1:0]   prdata_q, prdata_d;
  logic                pready_q, pready_d, pslverr_q, pslverr_d;
  rx_state_type        rx_st_q, rx_st_d;
  // Combinational strobes
  logic                apb_acc, apb_done, apb_wr, apb_rd, apb_rx_mem_wr;
  logic                tx_fin, tx_push, tx_pop, sec_push, sec_pop;
  logic                hw_we, hw_two;
  logic [RX_PTR_W-1:0] hw_addr, dat_addr, zero_addr;
  logic [DATA_W-1:0]   hw_data;

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CONTROL, OFS_STATUS, OFS_TX_COUNT, OFS_RX_COUNT, OFS_TX_DATA, OFS_RX_DATA,
      OFS_TX_RD_PTR, OFS_TX_WR_PTR, OFS_RX_RD_PTR, OFS_RX_WR_PTR, OFS_RX_START:
        reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction : reg_known

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;  size_en_d = size_en_q;  fw_d = fw_q;
    tx_count_d = tx_count_q;  rx_count_d = rx_count_q;
    tx_rd_d = tx_rd_q;  tx_wr_d = tx_wr_q;  rx_rd_d = rx_rd_q;
    rx_wr_d = rx_wr_q;  rx_start_d = rx_start_q;  hdr_d = hdr_q;
    tx_busy_d = tx_busy_q;  tx_sent_d = tx_sent_q;
    rx_hw_cnt_d = rx_hw_cnt_q;  rx_first_d = rx_first_q;  end_seen_d = end_seen_q;
    rx_st_d = rx_st_q;
    apb_acc = psel & penable & ~pready_q;
    apb_done = psel & penable & pready_q;
    apb_wr = apb_done & pwrite;
    apb_rd = apb_done & ~pwrite;
    apb_rx_mem_wr = apb_wr & paddr[13];
    pready_d = apb_acc;
    pslverr_d = apb_acc & (paddr[13:12] == WIN_REGS) & ~reg_known(paddr);
    prdata_d = prdata_q;
    if (apb_acc & ~pwrite) begin
      prdata_d = ZERO_WORD;
      if (paddr[13]) begin
        prdata_d = {rx_mem[{paddr[12:2], 1'b1}], rx_mem[{paddr[12:2], 1'b0}]};
      end else if (paddr[13:12] == WIN_TX_MEM) begin
        prdata_d = tx_mem[paddr[11:2]];
      end else begin
        case (paddr)
          OFS_CONTROL:   prdata_d = {28'h0000000, fw_q, size_en_q, 1'b0, mode_q};
          OFS_STATUS:    prdata_d = {28'h0000000, ~rx_first_q, tx_busy_q, rx_done_q, tx_done_q};
          OFS_TX_COUNT:  prdata_d = {16'h0000, tx_count_q};
          OFS_RX_COUNT:  prdata_d = {16'h0000, rx_count_q};
          OFS_RX_DATA:   prdata_d = {rx_mem[{rx_rd_q[12:2], 1'b1}], rx_mem[{rx_rd_q[12:2], 1'b0}]};
          OFS_TX_RD_PTR: prdata_d = {20'h00000, tx_rd_q};
          OFS_TX_WR_PTR: prdata_d = {20'h00000, tx_wr_q};
          OFS_RX_RD_PTR: prdata_d = {19'h00000, rx_rd_q};
          OFS_RX_WR_PTR: prdata_d = {19'h00000, rx_wr_q};
          OFS_RX_START:  prdata_d = {19'h00000, rx_start_q};
          default:       prdata_d = ZERO_WORD;
        endcase
      end
    end
    // Transmit mover: buffer to primary channel, one 16-bit word per cycle
    tx_fin = (tx_sent_q >= tx_count_q) | (tx_rd_q == tx_wr_q);
    tx_pop = (pri_cnt_q != 4'h0) & (~tx_out_vld_q | eng_tx_ready);
    tx_push = tx_busy_q & ~tx_fin & (pri_cnt_q < 4'(PRI_DEPTH));
    tx_out_d = tx_out_q;
    tx_out_vld_d = tx_out_vld_q & ~eng_tx_ready;
    if (tx_pop) begin
      tx_out_d = pri_mem[pri_rp_q];
      tx_out_vld_d = 1'b1;
    end
    pri_rp_d = tx_pop ? pri_rp_q + 3'h1 : pri_rp_q;
    pri_wp_d = tx_push ? pri_wp_q + 3'h1 : pri_wp_q;
    pri_cnt_d = pri_cnt_q + {3'h0, tx_push} - {3'h0, tx_pop};
    if (tx_push) begin
      tx_rd_d = tx_rd_q + TX_HWORD;
      tx_sent_d = tx_sent_q + CNT_HWORD;
    end
    tx_done_d = tx_done_q;
    if (apb_wr & (paddr == OFS_STATUS) & pwdata[ST_TX_DONE]) begin
      tx_done_d = 1'b0;
    end
    if (tx_busy_q & tx_fin & (pri_cnt_q == 4'h0) & ~tx_out_vld_q) begin
      tx_busy_d = 1'b0;
      tx_done_d = 1'b1;
    end
    // Receive side: secondary channel into the receive buffer
    sec_push = eng_rx_valid & rx_rdy_q;
    sec_pop = (sec_cnt_q != 2'h0) & (rx_st_q == RX_RUN) & ~apb_rx_mem_wr;
    dat_addr = (rx_first_q & size_en_q & (rx_wr_q == rx_start_q)) ?
               rx_start_q + RX_LWORD : rx_wr_q;
    zero_addr = {rx_wr_q[12:2] + {10'h000, rx_wr_q[1]}, 2'b00};
    hw_we = 1'b0;
    hw_two = 1'b0;
    hw_addr = dat_addr;
    hw_data = {16'h0000, sec_mem[sec_rp_q]};
    rx_done_d = rx_done_q;
    if (apb_wr & (paddr == OFS_STATUS) & pwdata[ST_RX_DONE]) begin
      rx_done_d = 1'b0;
    end
    if (eng_rx_end) begin
      end_seen_d = 1'b1;
    end
    case (rx_st_q)
      RX_RUN: begin
        if (sec_pop) begin
          hw_we = 1'b1;
          rx_wr_d = dat_addr + RX_HWORD;
          rx_hw_cnt_d = rx_hw_cnt_q + CNT_HWORD;
          rx_first_d = 1'b0;
          if (rx_first_q) begin
            hdr_d = dat_addr - RX_LWORD;
          end
        end else if (end_seen_q & (sec_cnt_q == 2'h0)) begin
          if (size_en_q) begin
            rx_st_d = RX_ZERO;
          end else begin
            rx_count_d = rx_hw_cnt_q;
            rx_done_d = 1'b1;
            rx_hw_cnt_d = 16'h0000;
            rx_first_d = 1'b1;
            end_seen_d = eng_rx_end;
          end
        end
      end
      RX_ZERO: begin
        if (~apb_rx_mem_wr) begin
          hw_we = 1'b1;
          hw_two = 1'b1;
          hw_addr = zero_addr;
          hw_data = ZERO_WORD;
          rx_wr_d = zero_addr + RX_LWORD;
          rx_st_d = RX_HDR;
        end
      end
      RX_HDR: begin
        if (~apb_rx_mem_wr) begin
          hw_we = 1'b1;
          hw_two = 1'b1;
          hw_addr = hdr_q;
          hw_data = {16'h0000, rx_hw_cnt_q};
          rx_count_d = rx_hw_cnt_q;
          rx_done_d = 1'b1;
          rx_hw_cnt_d = 16'h0000;
          rx_first_d = 1'b1;
          end_seen_d = eng_rx_end;
          rx_st_d = RX_RUN;
        end
      end
      default: rx_st_d = RX_RUN;
    endcase
    sec_wp_d = sec_push ? ~sec_wp_q : sec_wp_q;
    sec_rp_d = sec_pop ? ~sec_rp_q : sec_rp_q;
    sec_cnt_d = sec_cnt_q + {1'b0, sec_push} - {1'b0, sec_pop};
    rx_rdy_d = (sec_cnt_d < 2'(SEC_DEPTH)) & ~end_seen_d & (rx_st_d == RX_RUN);
    // Register writes and port side effects; software pointer writes win
    if (apb_wr) begin
      case (paddr)
        OFS_CONTROL: begin
          mode_d = pwdata[CTL_MODE];
          size_en_d = pwdata[CTL_SIZE_EN];
          fw_d = pwdata[CTL_FW];
          if (pwdata[CTL_START] & ~tx_busy_q) begin
            tx_busy_d = 1'b1;
            tx_sent_d = 16'h0000;
          end
        end
        OFS_TX_COUNT:  tx_count_d = pwdata[CNT_W-1:0];
        OFS_TX_DATA:   tx_wr_d = (mode_q == MODE_FIFO) ? tx_wr_q + TX_LWORD : tx_wr_q;
        OFS_TX_RD_PTR: tx_rd_d = {pwdata[TX_PTR_W-1:1], 1'b0};
        OFS_TX_WR_PTR: tx_wr_d = {pwdata[TX_PTR_W-1:2], 2'b00};
        OFS_RX_RD_PTR: rx_rd_d = {pwdata[RX_PTR_W-1:2], 2'b00};
        OFS_RX_WR_PTR: rx_wr_d = {pwdata[RX_PTR_W-1:1], 1'b0};
        OFS_RX_START:  rx_start_d = {pwdata[RX_PTR_W-1:2], 2'b00};
        default: ;
      endcase
    end
    if (apb_rd & (paddr == OFS_RX_DATA) & (mode_q == MODE_FIFO)) begin
      rx_rd_d = rx_rd_q + RX_LWORD;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_FIFO;  size_en_q <= 1'b0;  fw_q <= 1'b0;
      tx_done_q <= 1'b0;  rx_done_q <= 1'b0;  tx_busy_q <= 1'b0;
      rx_first_q <= 1'b1;  end_seen_q <= 1'b0;
      tx_count_q <= 16'h0000;  rx_count_q <= 16'h0000;
      tx_sent_q <= 16'h0000;  rx_hw_cnt_q <= 16'h0000;
      tx_rd_q <= 12'h000;  tx_wr_q <= 12'h000;
      rx_rd_q <= 13'h0000;  rx_wr_q <= 13'h0000;
      rx_start_q <= 13'h0000;  hdr_q <= 13'h0000;
      pri_wp_q <= 3'h0;  pri_rp_q <= 3'h0;  pri_cnt_q <= 4'h0;
      sec_wp_q <= 1'b0;  sec_rp_q <= 1'b0;  sec_cnt_q <= 2'h0;
      tx_out_q <= 16'h0000;  tx_out_vld_q <= 1'b0;  rx_rdy_q <= 1'b0;
      prdata_q <= ZERO_WORD;  pready_q <= 1'b0;  pslverr_q <= 1'b0;
      rx_st_q <= RX_RUN;
    end else begin
      mode_q <= mode_d;  size_en_q <= size_en_d;  fw_q <= fw_d;
      tx_done_q <= tx_done_d;  rx_done_q <= rx_done_d;  tx_busy_q <= tx_busy_d;
      rx_first_q <= rx_first_d;  end_seen_q <= end_seen_d;
      tx_count_q <= tx_count_d;  rx_count_q <= rx_count_d;
      tx_sent_q <= tx_sent_d;  rx_hw_cnt_q <= rx_hw_cnt_d;
      tx_rd_q <= tx_rd_d;  tx_wr_q <= tx_wr_d;
      rx_rd_q <= rx_rd_d;  rx_wr_q <= rx_wr_d;
      rx_start_q <= rx_start_d;  hdr_q <= hdr_d;
      pri_wp_q <= pri_wp_d;  pri_rp_q <= pri_rp_d;  pri_cnt_q <= pri_cnt_d;
      sec_wp_q <= sec_wp_d;  sec_rp_q <= sec_rp_d;  sec_cnt_q <= sec_cnt_d;
      tx_out_q <= tx_out_d;  tx_out_vld_q <= tx_out_vld_d;  rx_rdy_q <= rx_rdy_d;
      prdata_q <= prdata_d;  pready_q <= pready_d;  pslverr_q <= pslverr_d;
      rx_st_q <= rx_st_d;
    end
  end

  // Memories carry no reset; software initialises the buffers
  always_ff @(posedge pclk) begin
    if (tx_push) begin
      pri_mem[pri_wp_q] <= tx_rd_q[1] ? tx_mem[tx_rd_q[11:2]][31:16] : tx_mem[tx_rd_q[11:2]][15:0];
    end
    if (sec_push) begin
      sec_mem[sec_wp_q] <= eng_rx_data;
    end
    if (apb_wr & (paddr[13:12] == WIN_TX_MEM)) begin
      tx_mem[paddr[11:2]] <= pwdata;
    end else if (apb_wr & (paddr == OFS_TX_DATA) & (mode_q == MODE_FIFO)) begin
      tx_mem[tx_wr_q[11:2]] <= pwdata;
    end
    if (apb_rx_mem_wr) begin
      rx_mem[{paddr[12:2], 1'b0}] <= pwdata[15:0];
      rx_mem[{paddr[12:2], 1'b1}] <= pwdata[31:16];
    end
    if (hw_we) begin
      rx_mem[hw_addr[12:1]] <= hw_data[15:0];
      if (hw_two) begin
        rx_mem[{hw_addr[12:2], 1'b1}] <= hw_data[31:16];
      end
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign eng_tx_data  = tx_out_q;
  assign eng_tx_valid = tx_out_vld_q;
  assign eng_fw_load  = fw_q;
  assign eng_rx_ready = rx_rdy_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tx_port_step;
    apb_wr && paddr == OFS_TX_DATA && mode_q == MODE_FIFO |=> tx_wr_q == $past(tx_wr_q) + TX_LWORD;
  endproperty
  a_tx_port_step: assert property (p_tx_port_step) else $error("tx pointer step");
  property p_random_port_idle;
    apb_wr && paddr == OFS_TX_DATA && mode_q != MODE_FIFO |=> $stable(tx_wr_q);
  endproperty
  a_random_port_idle: assert property (p_random_port_idle) else $error("mode ignored");
  property p_rx_port_step;
    apb_rd && paddr == OFS_RX_DATA && mode_q == MODE_FIFO |=> rx_rd_q == $past(rx_rd_q) + RX_LWORD;
  endproperty
  a_rx_port_step: assert property (p_rx_port_step) else $error("rx pointer step");
  property p_eng_read_step;
    tx_push && !apb_wr |=> tx_rd_q == $past(tx_rd_q) + TX_HWORD;
  endproperty
  a_eng_read_step: assert property (p_eng_read_step) else $error("engine read step");
  property p_eng_write_step;
    sec_pop && rx_st_q == RX_RUN && !apb_wr |=> rx_wr_q == $past(dat_addr) + RX_HWORD;
  endproperty
  a_eng_write_step: assert property (p_eng_write_step) else $error("engine write step");
  property p_tx_stop;
    tx_busy_q && tx_fin && !apb_wr |=> $stable(tx_sent_q) && $stable(tx_rd_q);
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("sent past the end");
  property p_tx_complete;
    tx_busy_q && tx_fin && pri_cnt_q == 4'h0 && !tx_out_vld_q |=> tx_done_q && !tx_busy_q;
  endproperty
  a_tx_complete: assert property (p_tx_complete) else $error("no tx complete");
  property p_header_write;
    rx_st_q == RX_HDR && !apb_rx_mem_wr |=> rx_done_q && rx_count_q == $past(rx_hw_cnt_q)
      && rx_mem[$past(hdr_q[12:1])] == $past(rx_hw_cnt_q);
  endproperty
  a_header_write: assert property (p_header_write) else $error("bad size header");
  property p_zero_then_hdr;
    rx_st_q == RX_ZERO && !apb_rx_mem_wr |=> rx_st_q == RX_HDR;
  endproperty
  a_zero_then_hdr: assert property (p_zero_then_hdr) else $error("zero word skipped");
  property p_no_insert;
    rx_st_q == RX_RUN && !size_en_q |=> rx_st_q == RX_RUN;
  endproperty
  a_no_insert: assert property (p_no_insert) else $error("insertion while off");
  property p_fifo_depth;
    pri_cnt_q <= 4'(PRI_DEPTH) && sec_cnt_q <= 2'(SEC_DEPTH);
  endproperty
  a_fifo_depth: assert property (p_fifo_depth) else $error("channel overflow");
  c_tx_done: cover property (tx_busy_q ##1 !tx_busy_q && tx_done_q);
  c_rx_insert: cover property (rx_st_q == RX_ZERO ##1 rx_st_q == RX_HDR ##1 rx_done_q);
  c_fifo_read: cover property (apb_rd && paddr == OFS_RX_DATA && mode_q == MODE_FIFO);
endmodule : channel_frame_buffer_access
`default_nettype wire

// File: verif/engine_model.sv
// Purpose: Protocol engine stand-in on the far side of the channel
// Assumes: Same clock as the buffer unit
// Notes:   Takes transmit words with stalls, sends queued receive words
`timescale 1ns/100ps
`default_nettype none
module engine_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output var  logic        tx_ready,
  output var  logic [15:0] rx_data,
  output var  logic        rx_valid,
  input  wire logic        rx_ready,
  output var  logic        rx_end
);
  logic [15:0] txq[$];
  logic [15:0] rxq[$];
  logic [2:0]  tick_q;
  // Plain always: the bench also reaches into both queues
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q   <= 3'h0;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 16'h0000;
      rx_end   <= 1'b0;
    end else begin
      tick_q   <= tick_q + 3'h1;
      // Stalls three cycles of eight to test hold
      tx_ready <= (tick_q < 3'h5);
      if (tx_valid && tx_ready) begin
        txq.push_back(tx_data);
      end
      if (!rx_valid || rx_ready) begin
        if (rxq.size() > 0) begin
          rx_data  <= rxq.pop_front();
          rx_valid <= 1'b1;
          rx_end   <= 1'b0;
        end else begin
          // Idle bus toggles so stale data never matches
          rx_data  <= ~rx_data;
          rx_valid <= 1'b0;
          rx_end   <= rx_valid;
        end
      end else begin
        rx_end <= 1'b0;
      end
    end
  end
endmodule : engine_model
`default_nettype wire

// File: verif/channel_frame_buffer_access_tb.sv
// Purpose: Self-checking bench for one buffer unit channel
// Assumes: APB master tasks here, engine stand-in on the far side
// Notes:   Data from a bench LFSR with a fixed start value
`timescale 1ns/100ps
`default_nettype none
module channel_frame_buffer_access_tb;
  import buffer_access_pkg::*;
  logic              pclk, pready, pslverr, rerr, fw, txv, txr, rxv, rxr, rxe;
  logic              presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rdat, w0, w1;
  logic [HALF_W-1:0] txd, rxd, h[4];
  logic [15:0]       lf_q = 16'h1B1A;
  int                n_errors = 0, num_checks = 0;
  channel_frame_buffer_access dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eng_tx_data(txd), .eng_tx_valid(txv),
    .eng_tx_ready(txr), .eng_fw_load(fw), .eng_rx_data(rxd), .eng_rx_valid(rxv),
    .eng_rx_ready(rxr), .eng_rx_end(rxe));
  engine_model eng (.pclk(pclk), .presetn(presetn), .tx_data(txd), .tx_valid(txv),
    .tx_ready(txr), .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr), .rx_end(rxe));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [15:0] rnd16();
    lf_q = {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
    return lf_q;
  endfunction : rnd16
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until pready; one idle cycle between transfers
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends on pready; only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdat, exp);
  endtask : rd
  task automatic wait_st(input int b);
    do begin
      apb(1'b0, OFS_STATUS, 32'h00000000);
    end while (rdat[b] !== 1'b1);
  endtask : wait_st
  task automatic send(input int n);
    #1;
    for (int i = 0; i < n; i++) begin
      h[i] = rnd16();
      eng.rxq.push_back(h[i]);
    end
    @(posedge pclk);
  endtask : send
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_STATUS, 32'h00000000);
    apb(1'b0, 14'h002C, 32'h00000000);
    chk(32'(rerr), 32'h00000001);
    w0 = {rnd16(), rnd16()};
    w1 = {rnd16(), rnd16()};
    wr(OFS_TX_COUNT, 32'h00000006);
    wr(OFS_TX_DATA, w0);
    wr(OFS_TX_DATA, w1);
    rd(OFS_TX_WR_PTR, 32'h00000008);
    wr(OFS_CONTROL, 32'h0000000A);
    chk(32'(fw), 32'h00000001);
    wait_st(ST_TX_DONE);
    chk(rdat & 32'h0000000F, 32'h00000001);
    chk(32'(eng.txq.size()), 32'h00000003);
    chk({eng.txq[1], eng.txq[0]}, w0);
    chk({16'h0000, eng.txq[2]}, {16'h0000, w1[15:0]});
    rd(OFS_TX_RD_PTR, 32'h00000006);
    wr(OFS_STATUS, 32'h00000001);
    wr(OFS_CONTROL, 32'h00000000);
    send(4);
    wait_st(ST_RX_DONE);
    chk(rdat & 32'h0000000F, 32'h00000002);
    rd(OFS_RX_COUNT, 32'h00000008);
    rd(OFS_RX_DATA, {h[1], h[0]});
    rd(OFS_RX_DATA, {h[3], h[2]});
    rd(OFS_RX_WR_PTR, 32'h00000008);
    rd(OFS_RX_RD_PTR, 32'h00000008);
    wr(OFS_STATUS, 32'h00000002);
    wr(OFS_RX_START, 32'h00000010);
    wr(14'h2010, 32'h00000000);
    wr(OFS_RX_RD_PTR, 32'h00000010);
    wr(OFS_RX_WR_PTR, 32'h00000014);
    wr(OFS_CONTROL, 32'h00000004);
    send(3);
    wait_st(ST_RX_DONE);
    chk(rdat & 32'h0000000F, 32'h00000002);
    rd(OFS_RX_DATA, 32'h00000006);
    rd(OFS_RX_DATA, {h[1], h[0]});
    apb(1'b0, OFS_RX_DATA, 32'h00000000);
    chk(rdat & 32'h0000FFFF, {16'h0000, h[2]});
    rd(OFS_RX_DATA, 32'h00000000);
    rd(14'h2014, {h[1], h[0]});
    rd(OFS_RX_COUNT, 32'h00000006);
    wr(OFS_STATUS, 32'h00000002);
    w0 = {rnd16(), rnd16()};
    w1 = {rnd16(), rnd16()};
    wr(14'h1020, w0);
    wr(14'h1024, w1);
    wr(OFS_TX_RD_PTR, 32'h00000020);
    wr(OFS_TX_WR_PTR, 32'h00000028);
    wr(OFS_TX_COUNT, 32'h00000008);
    wr(OFS_CONTROL, 32'h00000001);
    wr(OFS_TX_DATA, 32'hFFFFFFFF);
    rd(OFS_TX_WR_PTR, 32'h00000028);
    eng.txq.delete();
    wr(OFS_CONTROL, 32'h00000003);
    wait_st(ST_TX_DONE);
    chk(rdat & 32'h0000000F, 32'h00000001);
    chk({eng.txq[1], eng.txq[0]}, w0);
    chk({eng.txq[3], eng.txq[2]}, w1);
    chk(32'(eng.txq.size()), 32'h00000004);
    end_sim();
  end
endmodule : channel_frame_buffer_access_tb
`default_nettype wire
